//--- verilog/sensor_spi_crc_register_port.sv
// Serial register port with frame CRC for the multiturn position sensor.
// Summary of operation
// - Serial link runs clock polarity 0, phase 0.
// - Sample input on rise, change output on fall.
// - One 32-bit frame reaches one 16-bit register.
// - Five-bit CRC x5+x2+1, seeded all ones.
// - Serial LFSR over frame bits 30 down to 5.
// - Read CRC: select, address, data, status, counter.
// - Write CRC: select, address, data, three trailing bits.
// - CRC covers exactly 26 bits each frame.
// - First bit of every frame is ignored.
// - Read data MSB first after last address bit.
// - Bit after read data is always one.
// - Two-bit conversion counter follows, wrapping.
// - Read frame ends with five CRC bits.
// - Serial output released when not transmitting.
// - Angle and position refresh only while deselected.
// - Write data taken MSB first on sixteen rises.
// - Three undefined bits, then five host CRC bits.
// - Supply under and over voltage in fault bits 0-3.
// - Identification words readable by ordinary reads with page 2 selected.
`timescale 1ns/1ps
module sensor_spi_crc_register_port #(
   parameter logic [15:0] TRACE_0 = 16'h1357, // Arbitrary value.
   parameter logic [15:0] TRACE_1 = 16'h2468, // Arbitrary value.
   parameter logic [15:0] TRACE_2 = 16'h369C, // Arbitrary value.
   parameter logic [15:0] PART_TYPE = 16'h0A5C // Arbitrary value.
) (
   input wire logic core_clk, // System clock.
   input wire logic reset_n, // Synchronous reset, active low.
   input wire logic serial_clk, // Link serial clock from host.
   input wire logic chip_select_n, // Frame select from host, active low.
   input wire logic serial_in, // Serial data from host.
   output logic serial_out, // Serial data to host.
   output logic serial_oe, // Drive enable for serial_out.
   input wire logic [15:0] angle_in, // Fresh angle result.
   input wire logic [15:0] absolute_position_in, // Fresh absolute position.
   input wire logic conv_done, // Pulse: conversion sequence completed.
   input wire logic [3:0] supply_fault_in, // Raw supply fault levels.
   input wire logic [15:4] other_fault_in, // Other fault set levels.
   output logic [4:0] page_sel, // Selected register page.
   output logic conv_start, // Pulse: conversion start written.
   output logic conv_abort, // Pulse: conversion abort written.
   output logic [15:0] fault_flags, // Sticky fault flags.
   output logic [1:0] conv_count, // Conversion counter.
   output logic wr_valid, // Pulse: accepted register write.
   output logic [5:0] wr_addr, // Address of accepted write.
   output logic [15:0] wr_data, // Data of accepted write.
   output logic crc_error // Pulse: write frame failed its CRC.
);

   function automatic logic [4:0] crc_step(input logic [4:0] c, input logic b);
      logic fb;
      fb = b ^ c[4];
      crc_step = {c[3], c[2], c[1] ^ fb, c[0], fb};
   endfunction

   // Link domain state.
   logic [4:0] bit_cnt_r;
   logic rw_r;
   logic [5:0] addr_r;
   logic [14:0] rx_sh_r;
   logic [4:0] crc_r;
   logic [3:0] crc_rx_r;
   logic [5:0] wr_addr_lk_r;
   logic [15:0] wr_data_lk_r;
   logic wr_done_r;
   logic err_done_r;
   logic [15:0] tx_sh_r;
   logic cov_bit;
   logic [15:0] rd_word;

   // Core domain state.
   logic cs_m_r;
   logic cs_high_r;
   logic [3:0] sup_m_r;
   logic [3:0] sup_s_r;
   logic [2:0] wr_sync_r;
   logic [2:0] err_sync_r;
   logic wr_pulse;
   logic err_pulse;
   logic [15:0] angle_r;
   logic [15:0] abs_r;
   logic [1:0] cnt_r;
   logic [1:0] cnt_snap_r;
   logic [15:0] fault_set;

   // The frame counter is cleared asynchronously by deselect, so a partial frame is dropped.
   always_ff @(posedge serial_clk or posedge chip_select_n) begin
      if (chip_select_n) begin
         bit_cnt_r <= 5'h00;
      end else begin
         bit_cnt_r <= bit_cnt_r + 5'h01;
      end
   end

   always_ff @(posedge serial_clk or posedge chip_select_n) begin
      if (chip_select_n) begin
         rw_r <= 1'b0;
         addr_r <= 6'h00;
         rx_sh_r <= 15'h0000;
      end else begin
         rx_sh_r <= {rx_sh_r[13:0], serial_in};
         if (bit_cnt_r == sensor_spi_pkg::EDGE_RW) begin
            rw_r <= serial_in;
         end
         if (bit_cnt_r > sensor_spi_pkg::EDGE_RW && bit_cnt_r <= sensor_spi_pkg::EDGE_ADDR_LAST) begin
            addr_r <= {addr_r[4:0], serial_in};
         end
      end
   end

   // Covered bit: host bits up to the address, then the returned bits on reads.
   assign cov_bit = (bit_cnt_r <= sensor_spi_pkg::EDGE_ADDR_LAST || rw_r) ? serial_in : serial_out;

   always_ff @(posedge serial_clk or posedge chip_select_n) begin
      if (chip_select_n) begin
         crc_r <= sensor_spi_pkg::CRC_SEED;
      end else if (bit_cnt_r == sensor_spi_pkg::EDGE_IGNORED) begin
         crc_r <= sensor_spi_pkg::CRC_SEED;
      end else if (bit_cnt_r <= sensor_spi_pkg::EDGE_COVER_LAST) begin
         crc_r <= crc_step(crc_r, cov_bit);
      end
   end

   // The write word has no deselect clear, so the core can still take it after the frame has ended.
   always_ff @(posedge serial_clk) begin
      if (rw_r && bit_cnt_r == sensor_spi_pkg::EDGE_DATA_LAST) begin
         wr_addr_lk_r <= addr_r;
         wr_data_lk_r <= {rx_sh_r, serial_in};
      end
   end

   // CRC check; a done flag stands from the last rise until the next rise or deselect.
   // The core takes only its rising edge, so a deselect right after the frame makes no second event.
   always_ff @(posedge serial_clk or posedge chip_select_n) begin
      if (chip_select_n) begin
         crc_rx_r <= 4'h0;
         wr_done_r <= 1'b0;
         err_done_r <= 1'b0;
      end else begin
         wr_done_r <= 1'b0;
         err_done_r <= 1'b0;
         if (bit_cnt_r >= sensor_spi_pkg::EDGE_CRC_FIRST) begin
            crc_rx_r <= {crc_rx_r[2:0], serial_in};
         end
         if (rw_r && bit_cnt_r == sensor_spi_pkg::EDGE_LAST) begin
            if ({crc_rx_r, serial_in} == crc_r) begin
               wr_done_r <= 1'b1;
            end else begin
               err_done_r <= 1'b1;
            end
         end
      end
   end

   // Angle and position are frozen during selection, so the link reads them as quasi-static; page and fault flags are not.
   always_comb begin
      rd_word = 16'h0000;
      case (addr_r)
         sensor_spi_pkg::ADDR_PAGE: rd_word = {11'h000, page_sel};
         sensor_spi_pkg::ADDR_ABS: rd_word = abs_r;
         sensor_spi_pkg::ADDR_ANGLE: rd_word = {angle_r[15:sensor_spi_pkg::ANGLE_LSB], 4'h0};
         sensor_spi_pkg::ADDR_FAULT: rd_word = fault_flags;
         sensor_spi_pkg::ADDR_TRACE0: rd_word = (page_sel == sensor_spi_pkg::ID_PAGE) ? TRACE_0 : 16'h0000;
         sensor_spi_pkg::ADDR_TRACE1: rd_word = (page_sel == sensor_spi_pkg::ID_PAGE) ? TRACE_1 : 16'h0000;
         sensor_spi_pkg::ADDR_TRACE2: rd_word = (page_sel == sensor_spi_pkg::ID_PAGE) ? TRACE_2 : 16'h0000;
         sensor_spi_pkg::ADDR_PART: rd_word = (page_sel == sensor_spi_pkg::ID_PAGE) ? PART_TYPE : 16'h0000;
         default: rd_word = 16'h0000;
      endcase
   end

   // Output side: bit_cnt_r here already counts the rise that preceded this fall.
   always_ff @(negedge serial_clk or posedge chip_select_n) begin
      if (chip_select_n) begin
         serial_out <= 1'b0;
         serial_oe <= 1'b0;
         tx_sh_r <= 16'h0000;
      end else if (rw_r || bit_cnt_r < sensor_spi_pkg::EDGE_DATA_FIRST) begin
         serial_out <= 1'b0;
         serial_oe <= 1'b0;
         tx_sh_r <= 16'h0000;
      end else begin
         serial_oe <= 1'b1;
         if (bit_cnt_r == sensor_spi_pkg::EDGE_DATA_FIRST) begin
            serial_out <= rd_word[15];
            tx_sh_r <= {rd_word[14:0], 1'b0};
         end else if (bit_cnt_r <= sensor_spi_pkg::EDGE_DATA_LAST) begin
            serial_out <= tx_sh_r[15];
            tx_sh_r <= {tx_sh_r[14:0], 1'b0};
         end else if (bit_cnt_r == sensor_spi_pkg::EDGE_STATUS) begin
            serial_out <= 1'b1;
         end else if (bit_cnt_r == sensor_spi_pkg::EDGE_CNT_HI) begin
            serial_out <= cnt_snap_r[1];
         end else if (bit_cnt_r == sensor_spi_pkg::EDGE_CNT_LO) begin
            serial_out <= cnt_snap_r[0];
         end else if (bit_cnt_r == sensor_spi_pkg::EDGE_CRC_FIRST) begin
            serial_out <= crc_r[4];
            tx_sh_r <= {crc_r[3:0], 12'h000};
         end else begin
            serial_out <= tx_sh_r[15];
            tx_sh_r <= {tx_sh_r[14:0], 1'b0};
         end
      end
   end

   // Crossings into the core clock.
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         cs_m_r <= 1'b1;
         cs_high_r <= 1'b1;
         sup_m_r <= 4'h0;
         sup_s_r <= 4'h0;
         wr_sync_r <= 3'h0;
         err_sync_r <= 3'h0;
      end else begin
         cs_m_r <= chip_select_n;
         cs_high_r <= cs_m_r;
         sup_m_r <= supply_fault_in;
         sup_s_r <= sup_m_r;
         wr_sync_r <= {wr_sync_r[1:0], wr_done_r};
         err_sync_r <= {err_sync_r[1:0], err_done_r};
      end
   end

   // Each done flag gives one core pulse at its rising edge, however long it stands.
   assign wr_pulse = wr_sync_r[1] & ~wr_sync_r[2];
   assign err_pulse = err_sync_r[1] & ~err_sync_r[2];

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         angle_r <= sensor_spi_pkg::ANGLE_RST;
         abs_r <= sensor_spi_pkg::ABS_RST;
         cnt_snap_r <= 2'b00;
      end else if (cs_high_r) begin
         angle_r <= angle_in;
         abs_r <= absolute_position_in;
         cnt_snap_r <= cnt_r;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         cnt_r <= 2'b00;
      end else if (conv_done) begin
         cnt_r <= cnt_r + 2'b01;
      end
   end

   assign fault_set = {other_fault_in, sup_s_r};

   // Writing zero clears the flags; a fault present in the same cycle stays set.
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         fault_flags <= sensor_spi_pkg::FAULT_RST;
      end else if (wr_pulse && wr_addr_lk_r == sensor_spi_pkg::ADDR_FAULT && wr_data_lk_r == 16'h0000) begin
         fault_flags <= fault_set;
      end else begin
         fault_flags <= fault_flags | fault_set;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         page_sel <= sensor_spi_pkg::PAGE_RST;
         conv_start <= 1'b0;
         conv_abort <= 1'b0;
      end else begin
         conv_start <= 1'b0;
         conv_abort <= 1'b0;
         if (wr_pulse && wr_addr_lk_r == sensor_spi_pkg::ADDR_PAGE) begin
            page_sel <= wr_data_lk_r[sensor_spi_pkg::PAGE_MSB:0];
            conv_start <= wr_data_lk_r[sensor_spi_pkg::CNV_MSB:sensor_spi_pkg::CNV_LSB] == sensor_spi_pkg::CNV_START;
            conv_abort <= wr_data_lk_r[sensor_spi_pkg::CNV_MSB:sensor_spi_pkg::CNV_LSB] == sensor_spi_pkg::CNV_ABORT;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         wr_valid <= 1'b0;
         wr_addr <= 6'h00;
         wr_data <= 16'h0000;
         crc_error <= 1'b0;
      end else begin
         wr_valid <= wr_pulse;
         crc_error <= err_pulse;
         if (wr_pulse) begin
            wr_addr <= wr_addr_lk_r;
            wr_data <= wr_data_lk_r;
         end
      end
   end

   assign conv_count = cnt_r;

   // Checks in the link domain.
   a_crc_seeded: assert property (@(posedge serial_clk) disable iff (chip_select_n)
      bit_cnt_r == sensor_spi_pkg::EDGE_IGNORED |=> crc_r == sensor_spi_pkg::CRC_SEED)
      else $error("CRC not seeded after first frame bit");
   a_status_one: assert property (@(posedge serial_clk) disable iff (chip_select_n)
      (!rw_r && bit_cnt_r == sensor_spi_pkg::EDGE_STATUS) |-> (serial_out && serial_oe))
      else $error("Status bit after read data is not one");
   a_counter_bits: assert property (@(posedge serial_clk) disable iff (chip_select_n)
      (!rw_r && bit_cnt_r == sensor_spi_pkg::EDGE_CNT_HI) |->
      serial_out == cnt_snap_r[1] ##1 serial_out == cnt_snap_r[0])
      else $error("Conversion counter bits wrong");
   a_crc_sent: assert property (@(posedge serial_clk) disable iff (chip_select_n)
      (!rw_r && bit_cnt_r == sensor_spi_pkg::EDGE_CRC_FIRST) |-> serial_out == crc_r[4] ##1 serial_out == crc_r[3])
      else $error("Read CRC bits wrong");
   a_read_window: assert property (@(posedge serial_clk) disable iff (chip_select_n)
      (!rw_r && bit_cnt_r > sensor_spi_pkg::EDGE_DATA_FIRST) |-> serial_oe)
      else $error("Output not driven during read reply");
   a_count_wraps: assert property (@(posedge serial_clk) disable iff (chip_select_n)
      bit_cnt_r == sensor_spi_pkg::EDGE_LAST |=> bit_cnt_r == sensor_spi_pkg::EDGE_IGNORED)
      else $error("Frame counter did not wrap at 32 bits");

   // Checks in the core domain.
   a_output_released: assert property (@(posedge core_clk) disable iff (!reset_n)
      (chip_select_n || (rw_r && bit_cnt_r > sensor_spi_pkg::EDGE_DATA_FIRST)) |-> !serial_oe)
      else $error("Serial output driven while not transmitting");
   a_freeze_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
      !cs_high_r |=> ($stable(angle_r) && $stable(abs_r)))
      else $error("Angle or position changed while selected");
   a_fault_sets: assert property (@(posedge core_clk) disable iff (!reset_n)
      sup_s_r[sensor_spi_pkg::FAULT_CORE_UV] |=> fault_flags[sensor_spi_pkg::FAULT_CORE_UV])
      else $error("Supply fault flag not set");
   a_write_commit: assert property (@(posedge core_clk) disable iff (!reset_n)
      wr_pulse |=> (wr_valid && wr_data == $past(wr_data_lk_r)) ##1 !wr_valid)
      else $error("Accepted write not presented once");

   c_read_done: cover property (@(posedge serial_clk) disable iff (chip_select_n)
      !rw_r && bit_cnt_r == sensor_spi_pkg::EDGE_LAST);
   c_write_done: cover property (@(posedge core_clk) disable iff (!reset_n) wr_valid);
   c_crc_bad: cover property (@(posedge core_clk) disable iff (!reset_n) crc_error);
   c_fault_hi: cover property (@(posedge core_clk) disable iff (!reset_n)
      fault_flags[sensor_spi_pkg::FAULT_IF_OV] && !fault_flags[sensor_spi_pkg::FAULT_CORE_UV]);
   c_frame_chain: cover property (@(posedge serial_clk) disable iff (chip_select_n)
      bit_cnt_r == sensor_spi_pkg::EDGE_LAST ##1 bit_cnt_r == sensor_spi_pkg::EDGE_IGNORED);

endmodule

//--- verilog/sensor_spi_pkg.sv
// Constants shared by the sensor serial register port.
package sensor_spi_pkg;
   // Serial clock rising-edge index within a 32-bit frame, 0 being the first edge.
   localparam logic [4:0] EDGE_IGNORED = 5'h00;
   localparam logic [4:0] EDGE_RW = 5'h01;
   localparam logic [4:0] EDGE_ADDR_LAST = 5'h07;
   localparam logic [4:0] EDGE_DATA_FIRST = 5'h08;
   localparam logic [4:0] EDGE_DATA_LAST = 5'h17;
   localparam logic [4:0] EDGE_STATUS = 5'h18;
   localparam logic [4:0] EDGE_CNT_HI = 5'h19;
   localparam logic [4:0] EDGE_CNT_LO = 5'h1A;
   localparam logic [4:0] EDGE_CRC_FIRST = 5'h1B;
   localparam logic [4:0] EDGE_LAST = 5'h1F;
   localparam logic [4:0] EDGE_COVER_LAST = 5'h1A;
   localparam logic [4:0] CRC_SEED = 5'h1F;
   // Register addresses and the page that holds the identification words.
   localparam logic [5:0] ADDR_PAGE = 6'h01;
   localparam logic [5:0] ADDR_ABS = 6'h03;
   localparam logic [5:0] ADDR_ANGLE = 6'h05;
   localparam logic [5:0] ADDR_FAULT = 6'h06;
   localparam logic [5:0] ADDR_TRACE0 = 6'h1E;
   localparam logic [5:0] ADDR_TRACE1 = 6'h1F;
   localparam logic [5:0] ADDR_TRACE2 = 6'h20;
   localparam logic [5:0] ADDR_PART = 6'h21;
   localparam logic [4:0] ID_PAGE = 5'h02;
   // Reset values.
   localparam logic [15:0] ANGLE_RST = 16'h8000;
   localparam logic [15:0] ABS_RST = 16'hDB00;
   localparam logic [15:0] FAULT_RST = 16'hFFFF;
   localparam logic [4:0] PAGE_RST = 5'h00;
   // Field layout.
   localparam int PAGE_MSB = 4;
   localparam int CNV_MSB = 15;
   localparam int CNV_LSB = 14;
   localparam logic [1:0] CNV_START = 2'b00;
   localparam logic [1:0] CNV_ABORT = 2'b11;
   localparam int FAULT_CORE_UV = 0;
   localparam int FAULT_IF_OV = 3;
   localparam int ANGLE_LSB = 4;
endpackage

//--- dv/spi_host_model.sv
// Host controller model that frames mode 0 transfers towards the sensor port.
`timescale 1ns/1ps
module spi_host_model (
   output logic serial_clk, // Link clock, still outside frames.
   output logic chip_select_n, // Frame select, active low.
   output logic serial_in, // Data to the device.
   input wire logic serial_out_line // Resolved device output line.
);
   initial begin
      serial_clk = 1'b0;
      chip_select_n = 1'b1;
      serial_in = 1'b0;
   end
   // Shifts nbits of tx, MSB first; a short count leaves the frame incomplete.
   task automatic xfer(input logic [31:0] tx, input int nbits, input bit keep, output logic [31:0] rx);
      int i;
      rx = 32'h00000000;
      #7;
      chip_select_n = 1'b0;
      for (i = 31; i >= 32 - nbits; i--) begin
         serial_in = tx[i];
         #15 serial_clk = 1'b1;
         rx[i] = serial_out_line;
         #15 serial_clk = 1'b0;
      end
      // The idle line shows the inverse of the last bit, never a stale value.
      serial_in = ~serial_in;
      if (!keep) begin
         chip_select_n = 1'b1;
      end
   endtask
endmodule

//--- dv/tb_sensor_spi_crc_register_port.sv
// Self-checking testbench for the sensor serial register port.
`timescale 1ns/1ps
module tb_sensor_spi_crc_register_port;
   localparam logic [15:0] ID_VAL [4] = '{16'h1357, 16'h2468, 16'h369C, 16'h0A5C}; // Arbitrary values.
   logic core_clk, reset_n, serial_clk, chip_select_n, serial_in, serial_out, serial_oe;
   logic [15:0] angle_in, absolute_position_in, fault_flags, wr_data;
   logic conv_done, conv_start, conv_abort, wr_valid, crc_error;
   logic [3:0] supply_fault_in;
   logic [15:4] other_fault_in;
   logic [4:0] page_sel;
   logic [1:0] conv_count;
   logic [5:0] wr_addr;
   logic [31:0] rx;
   wire serial_out_line;
   int err_count, compares, wr_cnt, bad_cnt, start_cnt, abort_cnt, i;
   assign serial_out_line = serial_oe ? serial_out : 1'bz;
   sensor_spi_crc_register_port #(.TRACE_0(ID_VAL[0]), .TRACE_1(ID_VAL[1]), .TRACE_2(ID_VAL[2]),
      .PART_TYPE(ID_VAL[3])) dut (.core_clk(core_clk), .reset_n(reset_n), .serial_clk(serial_clk),
      .chip_select_n(chip_select_n), .serial_in(serial_in), .serial_out(serial_out), .serial_oe(serial_oe),
      .angle_in(angle_in), .absolute_position_in(absolute_position_in), .conv_done(conv_done),
      .supply_fault_in(supply_fault_in), .other_fault_in(other_fault_in), .page_sel(page_sel),
      .conv_start(conv_start), .conv_abort(conv_abort), .fault_flags(fault_flags), .conv_count(conv_count),
      .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .crc_error(crc_error));
   spi_host_model host (.serial_clk(serial_clk), .chip_select_n(chip_select_n), .serial_in(serial_in),
      .serial_out_line(serial_out_line));
   always #2.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (wr_valid === 1'b1) wr_cnt++;
      if (crc_error === 1'b1) bad_cnt++;
      if (conv_start === 1'b1) start_cnt++;
      if (conv_abort === 1'b1) abort_cnt++;
   end
   function automatic logic [4:0] crc5(input logic [31:0] w);
      logic [4:0] c;
      logic fb;
      c = 5'h1F;
      for (int k = 30; k >= 5; k--) begin
         fb = w[k] ^ c[4];
         c = {c[3], c[2], c[1] ^ fb, c[0], fb};
      end
      return c;
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Read frame; the ignored leading bit is sent high on purpose.
   task automatic rd(input logic [5:0] a, input logic [15:0] d, input logic [1:0] cnt, input bit keep);
      logic [31:0] tx, got, e;
      logic fresh;
      fresh = chip_select_n;
      tx = {2'b10, a, 24'h000000};
      host.xfer(tx, 32, keep, got);
      e = {tx[31:24], d, 1'b1, cnt, 5'h00};
      e[4:0] = crc5(e);
      check({8'h00, got[23:0]}, {8'h00, e[23:0]});
      if (fresh) check({24'h000000, got[31:24]}, {24'h000000, 8'hzz});
   endtask
   task automatic wr(input logic [5:0] a, input logic [15:0] d, input bit bad, input bit lead);
      logic [31:0] tx, got;
      tx = {lead, 1'b1, a, d, 3'b101, 5'h00};
      tx[4:0] = crc5(tx) ^ {4'h0, bad};
      host.xfer(tx, 32, 1'b0, got);
      repeat (12) @(negedge core_clk);
   endtask
   task automatic print_verdict;
      $display("compares=%0d err_count=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      #200000;
      err_count++;
      print_verdict();
   end
   initial begin
      core_clk = 1'b0;
      reset_n = 1'b0;
      angle_in = 16'h1234;
      absolute_position_in = 16'h5678;
      conv_done = 1'b0;
      supply_fault_in = 4'h0;
      other_fault_in = 12'h000;
      repeat (16) @(negedge core_clk);
      reset_n = 1'b1;
      repeat (6) @(negedge core_clk);
      check({11'h000, page_sel, fault_flags}, 32'h0000FFFF);
      rd(sensor_spi_pkg::ADDR_FAULT, 16'hFFFF, 2'h0, 1'b0);
      #1 check({31'h0, serial_oe}, 32'h0);
      wr(sensor_spi_pkg::ADDR_FAULT, 16'h0000, 1'b0, 1'b0);
      check({wr_cnt[9:0], wr_addr, wr_data}, {10'h001, sensor_spi_pkg::ADDR_FAULT, 16'h0000});
      check({16'h0000, fault_flags}, 32'h0);
      wr(sensor_spi_pkg::ADDR_PAGE, 16'h0002, 1'b1, 1'b1);
      check({wr_cnt[7:0], bad_cnt[7:0], 11'h0, page_sel}, {8'h01, 8'h01, 16'h0000});
      host.xfer({2'b01, sensor_spi_pkg::ADDR_PAGE, 16'h0002, 8'h00}, 20, 1'b0, rx);
      repeat (12) @(negedge core_clk);
      check({wr_cnt[7:0], bad_cnt[7:0], 16'h0}, {8'h01, 8'h01, 16'h0});
      wr(sensor_spi_pkg::ADDR_PAGE, 16'h0002, 1'b0, 1'b1);
      check({start_cnt[7:0], 19'h0, page_sel}, {8'h01, 19'h0, sensor_spi_pkg::ID_PAGE});
      for (i = 0; i < 4; i++) begin
         rd(sensor_spi_pkg::ADDR_TRACE0 + 6'(i), ID_VAL[i], 2'h0, 1'b0);
      end
      wr(sensor_spi_pkg::ADDR_PAGE, 16'hC000, 1'b0, 1'b0);
      check({abort_cnt[7:0], 19'h0, page_sel}, {8'h01, 24'h0});
      rd(sensor_spi_pkg::ADDR_TRACE0, 16'h0000, 2'h0, 1'b0);
      for (i = 0; i < 5; i++) begin
         @(negedge core_clk);
         conv_done = 1'b1;
         @(negedge core_clk);
         conv_done = 1'b0;
      end
      repeat (4) @(negedge core_clk);
      check({30'h0, conv_count}, 32'h1);
      rd(sensor_spi_pkg::ADDR_ANGLE, 16'h1230, 2'h1, 1'b1);
      @(negedge core_clk);
      angle_in = 16'hABCD;
      absolute_position_in = 16'h9999;
      rd(sensor_spi_pkg::ADDR_ABS, 16'h5678, 2'h1, 1'b0);
      repeat (8) @(negedge core_clk);
      rd(sensor_spi_pkg::ADDR_ABS, 16'h9999, 2'h1, 1'b1);
      rd(sensor_spi_pkg::ADDR_ANGLE, 16'hABC0, 2'h1, 1'b0);
      @(negedge core_clk);
      supply_fault_in = 4'hA;
      repeat (8) @(negedge core_clk);
      check({16'h0, fault_flags}, 32'h0000000A);
      rd(sensor_spi_pkg::ADDR_FAULT, 16'h000A, 2'h1, 1'b0);
      @(negedge core_clk);
      supply_fault_in = 4'h5;
      repeat (8) @(negedge core_clk);
      supply_fault_in = 4'h0;
      repeat (8) @(negedge core_clk);
      check({16'h0, fault_flags}, 32'h0000000F);
      wr(sensor_spi_pkg::ADDR_FAULT, 16'h0000, 1'b0, 1'b1);
      check({16'h0, fault_flags}, 32'h0);
      print_verdict();
   end
endmodule
